// file: hw/dsct_ctrl.sv
`include "dsct_cfg.svh"
// Contract
// - row access 120 ns; column delay 15-50
// - refresh every row within 4 ms
// - row strobe low 120 to 10000 ns
// - column strobe low 70 to 10000 ns
// - row strobe high 80 ns precharge
// - page column strobe high 50 ns
// - read/write cycle starts 230 ns apart
// - read-modify-write cycle at least 255 ns
// - page column cycles 130 ns apart
// - rmw write 40 after column, 110 row
// - write low 50 ns before strobes rise
// - early write low before column falls; the code drops write select on the same edge as the column strobe
// - write pulse at least 40 ns
// - row low 70 after column; column 120
// - stretch strobes to meet write timings
// - eight row then eight column bits
// - refresh by row strobe over 256 rows
// - power-up 100 us high, eight cycles
module dsct_ctrl
  import dsct_pkg::*;
#(
  parameter int PWRUP_CYC = `DSCT_CYC_MIN(`DSCT_PWRUP_NS),
  parameter int REF_CYC = `DSCT_CYC_MAX(`DSCT_REF_INT_NS)
) (
  input wire logic core_clk_in, // clock, 100 MHz
  input wire logic srst_in, // sync reset, high
  input wire logic req_valid_in, // access request
  input wire dsct_op_t req_op_in, // read, write or rmw
  input wire logic [15:0] req_addr_in, // row in high byte
  input wire logic req_wdata_in, // write data bit
  input wire logic req_page_in, // keep row open for next
  input wire logic dram_q_in, // memory data out
  output logic req_ready_out, // request taken at the last edge
  output logic rsp_valid_out, // read data pulse
  output logic rsp_rdata_out, // read data
  output logic init_done_out, // initialisation finished
  output logic ras_n_out, // row strobe
  output logic cas_n_out, // column strobe
  output logic we_n_out, // write select
  output logic [7:0] muxed_address_out, // multiplexed address
  output logic dram_d_out // memory data in
);
  localparam int C_RCD = `DSCT_CYC_MIN(`DSCT_T_RCD_MIN_NS);
  localparam int C_CAC = `DSCT_CYC_MIN(`DSCT_T_CAC_NS);
  localparam int C_RAC = `DSCT_CYC_MIN(`DSCT_T_RAC_NS);
  localparam int C_RAS = `DSCT_CYC_MIN(`DSCT_T_RAS_NS);
  localparam int C_CAS = `DSCT_CYC_MIN(`DSCT_T_CAS_NS);
  localparam int C_RP = `DSCT_CYC_MIN(`DSCT_T_RP_NS);
  localparam int C_CP = `DSCT_CYC_MIN(`DSCT_T_CP_NS);
  localparam int C_RC = `DSCT_CYC_MIN(`DSCT_T_RC_NS);
  localparam int C_RWC = `DSCT_CYC_MIN(`DSCT_T_RWC_NS);
  localparam int C_PC = `DSCT_CYC_MIN(`DSCT_T_PC_NS);
  localparam int C_CWD = `DSCT_CYC_MIN(`DSCT_T_CWD_NS);
  localparam int C_RWD = `DSCT_CYC_MIN(`DSCT_T_RWD_NS);
  localparam int C_CWL = `DSCT_CYC_MIN(`DSCT_T_CWL_NS);
  localparam int C_WP = `DSCT_CYC_MIN(`DSCT_T_WP_NS);
  localparam int C_RSH = `DSCT_CYC_MIN(`DSCT_T_RSH_NS);
  localparam int C_CSH = `DSCT_CYC_MIN(`DSCT_T_CSH_NS);
  localparam int C_OFF = `DSCT_CYC_MIN(`DSCT_T_OFF_NS);
  localparam int C_RASMAX = `DSCT_CYC_MAX(`DSCT_T_RAS_MAX_NS);

  function automatic logic [15:0] max3(input int a, input int b, input int c);
    int m;
    m = a;
    if (b > m) m = b;
    if (c > m) m = c;
    return m[15:0];
  endfunction : max3

  dsct_state_t state;
  dsct_op_t op;
  logic [15:0] st_cnt; // cycles in current state
  logic [15:0] ras_cnt; // cycles since row strobe fell
  logic [15:0] cas_cnt; // cycles since column strobe fell
  logic [15:0] wr_cnt; // cycles since write select fell
  logic [16:0] pwr_cnt;
  logic [3:0] init_cnt;
  logic [15:0] ref_tmr;
  logic ref_pend;
  logic [15:0] ref_wait; // cycles a refresh has waited since init
  logic ref_mode; // row strobe belongs to a refresh
  logic [7:0] ref_row;
  logic [7:0] open_row;
  logic row_open;
  logic wdata;
  logic [7:0] col;
  logic next_page;

  wire logic ref_tick = (ref_tmr == REF_CYC[15:0] - 16'h0001);
  wire logic take = req_valid_in && !ref_pend && init_done_out &&
    (state == DSCT_IDLE || (state == DSCT_HOLD && row_open &&
     req_addr_in[15:8] == open_row && st_cnt >= 16'(C_CP - 1)));
  // rmw needs write after the read access and far enough from both strobes
  wire logic [15:0] rmw_cas_wait = max3(C_CWD, C_CAC, C_RWD - C_RCD);

  always_ff @(posedge core_clk_in) begin
    if (srst_in || ref_tick) ref_tmr <= 16'h0000;
    else ref_tmr <= ref_tmr + 16'h0001;
  end

  // refresh request set wins over its clear
  always_ff @(posedge core_clk_in) begin
    if (srst_in) ref_pend <= 1'b0;
    else if (ref_tick) ref_pend <= 1'b1;
    else if (state == DSCT_REF && st_cnt == 16'h0000) ref_pend <= 1'b0;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) ref_row <= 8'h00;
    else if (state == DSCT_REF && st_cnt == 16'h0000 && init_done_out)
      ref_row <= ref_row + 8'h01;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pwr_cnt <= 17'h00000;
      init_cnt <= 4'h0;
      init_done_out <= 1'b0;
    end else begin
      if (state == DSCT_PWRUP) pwr_cnt <= pwr_cnt + 17'h00001;
      if (state == DSCT_REF && st_cnt == 16'h0000 && !init_done_out)
        init_cnt <= init_cnt + 4'h1;
      if (init_cnt == 4'(`DSCT_INIT_CYCLES) && state == DSCT_IDLE)
        init_done_out <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ras_cnt <= 16'h0000;
      cas_cnt <= 16'h0000;
      wr_cnt <= 16'h0000;
    end else begin
      ras_cnt <= ras_n_out ? 16'h0000 : ras_cnt + 16'h0001;
      cas_cnt <= cas_n_out ? 16'h0000 : cas_cnt + 16'h0001;
      wr_cnt <= we_n_out ? 16'h0000 : wr_cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state <= DSCT_PWRUP;
      st_cnt <= 16'h0000;
      op <= DSCT_OP_READ;
      ras_n_out <= 1'b1;
      cas_n_out <= 1'b1;
      we_n_out <= 1'b1;
      muxed_address_out <= 8'h00;
      dram_d_out <= 1'b0;
      req_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= 1'b0;
      row_open <= 1'b0;
      open_row <= 8'h00;
      ref_mode <= 1'b0;
      wdata <= 1'b0;
      col <= 8'h00;
      next_page <= 1'b0;
    end else begin
      st_cnt <= st_cnt + 16'h0001;
      req_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      case (state)
        DSCT_PWRUP: begin
          if (pwr_cnt >= 17'(PWRUP_CYC)) begin
            state <= DSCT_REF;
            st_cnt <= 16'h0000;
            ras_n_out <= 1'b0;
            ref_mode <= 1'b1;
          end
        end
        DSCT_IDLE: begin
          // after the eighth init cycle nothing starts until the done flag stands
          if ((!init_done_out && init_cnt != 4'(`DSCT_INIT_CYCLES)) ||
              (init_done_out && ref_pend)) begin
            state <= DSCT_REF;
            st_cnt <= 16'h0000;
            muxed_address_out <= ref_row;
            ras_n_out <= 1'b0;
            ref_mode <= 1'b1;
          end else if (take) begin
            req_ready_out <= 1'b1;
            op <= req_op_in;
            wdata <= req_wdata_in;
            col <= req_addr_in[7:0];
            next_page <= req_page_in;
            open_row <= req_addr_in[15:8];
            muxed_address_out <= req_addr_in[15:8];
            ras_n_out <= 1'b0;
            state <= DSCT_RAS;
            st_cnt <= 16'h0000;
          end
        end
        DSCT_RAS: begin
          if (st_cnt >= 16'(C_RCD - 1)) begin
            muxed_address_out <= col;
            cas_n_out <= 1'b0;
            we_n_out <= (op != DSCT_OP_WRITE);
            dram_d_out <= wdata;
            row_open <= 1'b1;
            state <= DSCT_CAS;
            st_cnt <= 16'h0000;
          end
        end
        DSCT_CAS: begin
          if (op == DSCT_OP_RMW && st_cnt >= rmw_cas_wait - 16'h0001 &&
              ras_cnt >= 16'(C_RAC - 1)) begin
            rsp_rdata_out <= dram_q_in;
            rsp_valid_out <= 1'b1;
            we_n_out <= 1'b0;
            state <= DSCT_WR;
            st_cnt <= 16'h0000;
          end else if (op != DSCT_OP_RMW && st_cnt >= 16'(C_CAC - 1) &&
                       ras_cnt >= 16'(C_RAC - 1)) begin
            if (op == DSCT_OP_READ) begin
              rsp_rdata_out <= dram_q_in;
              rsp_valid_out <= 1'b1;
            end
            state <= DSCT_WAIT;
            st_cnt <= 16'h0000;
          end
        end
        DSCT_WR: begin
          if (st_cnt >= 16'(max3(C_CWL, C_WP, 0) - 1)) state <= DSCT_WAIT;
        end
        DSCT_WAIT: begin
          if (cas_cnt >= 16'(C_CAS) && ras_cnt >= 16'(max3(C_CSH, C_RAC, 0))) begin
            cas_n_out <= 1'b1;
            we_n_out <= 1'b1;
            if (next_page && !ref_pend && ras_cnt < 16'(C_RASMAX - C_PC - 8)) begin
              state <= DSCT_HOLD;
            end else begin
              ras_n_out <= 1'b1;
              row_open <= 1'b0;
              state <= DSCT_RPRE;
            end
            st_cnt <= 16'h0000;
          end
        end
        DSCT_HOLD: begin
          if (take && st_cnt + cas_cnt >= 16'(C_PC - C_CAS)) begin
            req_ready_out <= 1'b1;
            op <= req_op_in;
            wdata <= req_wdata_in;
            next_page <= req_page_in;
            muxed_address_out <= req_addr_in[7:0];
            cas_n_out <= 1'b0;
            we_n_out <= (req_op_in != DSCT_OP_WRITE);
            dram_d_out <= req_wdata_in;
            state <= DSCT_CAS;
            st_cnt <= 16'h0000;
          // a request for another row closes the page at once
          end else if (ref_pend || !req_valid_in || req_addr_in[15:8] != open_row ||
                       ras_cnt >= 16'(C_RASMAX - C_PC - 8)) begin
            ras_n_out <= 1'b1;
            row_open <= 1'b0;
            state <= DSCT_RPRE;
            st_cnt <= 16'h0000;
          end
        end
        DSCT_REF: begin
          if (st_cnt >= 16'(C_RAS - 1)) begin
            ras_n_out <= 1'b1;
            ref_mode <= 1'b0;
            state <= DSCT_RPRE;
            st_cnt <= 16'h0000;
          end
        end
        DSCT_CPRE: state <= DSCT_RPRE;
        DSCT_RPRE: begin
          if (st_cnt >= 16'(C_RP - 1) &&
              st_cnt + 16'h0001 + 16'(C_RAS) >= 16'((op == DSCT_OP_RMW) ? C_RWC : C_RC)) begin
            state <= DSCT_IDLE;
            st_cnt <= 16'h0000;
          end
        end
        default: state <= DSCT_IDLE;
      endcase
    end
  end

  // ticks lost during the power-up wait do not matter, so only count after init
  always_ff @(posedge core_clk_in) begin
    if (srst_in || !ref_pend || !init_done_out) ref_wait <= 16'h0000;
    else ref_wait <= ref_wait + 16'h0001;
  end

  a_ras_precharge: assert property (@(posedge core_clk_in) disable iff (srst_in)
    $rose(ras_n_out) |-> ras_n_out [*8]) else $error("row precharge short");
  // the low time is counted, too long to unroll as a repetition
  a_ras_low_min: assert property (@(posedge core_clk_in) disable iff (srst_in)
    $rose(ras_n_out) |-> ras_cnt >= 16'(C_RAS)) else $error("row low short");
  a_cas_low_min: assert property (@(posedge core_clk_in) disable iff (srst_in)
    $fell(cas_n_out) |-> !cas_n_out [*7]) else $error("column low short");
  a_cas_after_ras: assert property (@(posedge core_clk_in) disable iff (srst_in)
    $fell(cas_n_out) |-> !ras_n_out && ras_cnt >= 16'(C_RCD)) else $error("column early");
  a_cas_high_page: assert property (@(posedge core_clk_in) disable iff (srst_in)
    $rose(cas_n_out) && !ras_n_out |-> cas_n_out [*5]) else $error("page precharge");
  a_we_pulse_min: assert property (@(posedge core_clk_in) disable iff (srst_in)
    $fell(we_n_out) |-> !we_n_out [*4]) else $error("write pulse short");
  a_we_before_rise: assert property (@(posedge core_clk_in) disable iff (srst_in)
    $rose(cas_n_out) && !$past(we_n_out) |-> wr_cnt >= 16'(C_CWL) ||
    $past(wr_cnt) >= 16'(C_CWL - 1)) else $error("write setup");
  a_ras_low_max: assert property (@(posedge core_clk_in) disable iff (srst_in)
    ras_cnt <= 16'(C_RASMAX)) else $error("row low too long");
  a_rmw_write_delay: assert property (@(posedge core_clk_in) disable iff (srst_in)
    $fell(we_n_out) && op == DSCT_OP_RMW |-> cas_cnt >= 16'(C_CWD) &&
    ras_cnt >= 16'(C_RWD)) else $error("rmw write early");
  // one access in flight plus its precharge stays well under two rmw cycles
  a_ref_served: assert property (@(posedge core_clk_in) disable iff (srst_in)
    ref_wait <= 16'(2 * C_RWC)) else $error("refresh late");
  c_read: cover property (@(posedge core_clk_in) rsp_valid_out && op == DSCT_OP_READ);
  c_rmw: cover property (@(posedge core_clk_in) rsp_valid_out && op == DSCT_OP_RMW);
  c_page: cover property (@(posedge core_clk_in) state == DSCT_HOLD ##1 state == DSCT_CAS);
  c_refresh: cover property (@(posedge core_clk_in) $fell(ras_n_out) && ref_mode);
endmodule : dsct_ctrl

// file: include/dsct_cfg.svh
`ifndef DSCT_CFG_SVH
`define DSCT_CFG_SVH
`define DSCT_CLK_NS 10
`define DSCT_CYC_MIN(ns) (((ns) + `DSCT_CLK_NS - 1) / `DSCT_CLK_NS)
`define DSCT_CYC_MAX(ns) ((ns) / `DSCT_CLK_NS)
`define DSCT_T_CAC_NS 70
`define DSCT_T_RAC_NS 120
`define DSCT_T_OFF_NS 40
`define DSCT_T_RAS_NS 120
`define DSCT_T_RAS_MAX_NS 10000
`define DSCT_T_CAS_NS 70
`define DSCT_T_RP_NS 80
`define DSCT_T_CP_NS 50
`define DSCT_T_RC_NS 230
`define DSCT_T_RWC_NS 255
`define DSCT_T_PC_NS 130
`define DSCT_T_RCD_MIN_NS 15
`define DSCT_T_RCD_MAX_NS 50
`define DSCT_T_CWD_NS 40
`define DSCT_T_RWD_NS 110
`define DSCT_T_CWL_NS 50
`define DSCT_T_WP_NS 40
`define DSCT_T_RSH_NS 70
`define DSCT_T_CSH_NS 120
`define DSCT_REF_INT_NS 15600
`define DSCT_PWRUP_NS 100000
`define DSCT_INIT_CYCLES 8
`define DSCT_ROWS 256
`endif

// file: include/dsct_pkg.sv
package dsct_pkg;
  typedef enum logic [9:0] {
    DSCT_PWRUP = 10'h001,
    DSCT_IDLE = 10'h002,
    DSCT_RAS = 10'h004,
    DSCT_CAS = 10'h008,
    DSCT_WAIT = 10'h010,
    DSCT_WR = 10'h020,
    DSCT_HOLD = 10'h040,
    DSCT_CPRE = 10'h080,
    DSCT_RPRE = 10'h100,
    DSCT_REF = 10'h200
  } dsct_state_t;
  typedef enum logic [1:0] {
    DSCT_OP_READ = 2'h0,
    DSCT_OP_WRITE = 2'h1,
    DSCT_OP_RMW = 2'h2
  } dsct_op_t;
endpackage : dsct_pkg

// file: tb/dsct_dram_model.sv
module dsct_dram_model #(
  parameter int ACC_NS = 65, // a little inside the worst-case column access
  parameter int RAC_NS = 115 // a little inside the worst-case row access
) (
  input wire logic ras_n_in, // row strobe
  input wire logic cas_n_in, // column strobe
  input wire logic we_n_in, // write select
  input wire logic [7:0] addr_in, // multiplexed address
  input wire logic d_in, // write data
  output logic q_out // read data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic mem [65536];
  logic [7:0] row;
  logic [15:0] adr;
  logic qv;
  logic early;
  logic valid;
  realtime t_ras;
  // outside the valid window the pin shows the inverted bit, so a lucky match is impossible
  assign q_out = valid ? qv : ~qv;
  initial begin
    valid = 1'b0;
    qv = 1'b0;
    early = 1'b0;
    t_ras = 0;
    for (int i = 0; i < 65536; i++) mem[i] = 1'b0;
  end
  always @(negedge ras_n_in) begin
    t_ras = $realtime;
    #1 row = addr_in;
  end
  always @(negedge cas_n_in) begin
    valid = 1'b0;
    #1;
    adr = {row, addr_in};
    early = !we_n_in;
    qv = mem[adr];
    if (early) mem[adr] = d_in;
    #(ACC_NS - 1);
    // an early column strobe leaves the row access in charge
    if ($realtime < t_ras + RAC_NS) #(t_ras + RAC_NS - $realtime);
    valid = !early && !cas_n_in;
  end
  // late write select: data strobed by the write-select fall; waits for the
  // column block to latch the address and early flag of this cycle
  always @(negedge we_n_in) #2 if (!cas_n_in && !early) mem[adr] = d_in;
  always @(posedge cas_n_in) valid = 1'b0;
endmodule : dsct_dram_model

// file: tb/dsct_ctrl_tb.sv
module dsct_ctrl_tb;
  import dsct_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PW = 50;
  localparam int RC = 200;
  logic core_clk_in, srst_in, req_valid_in, req_wdata_in, req_page_in, dram_q_in;
  logic req_ready_out, rsp_valid_out, rsp_rdata_out, init_done_out;
  logic ras_n_out, cas_n_out, we_n_out, dram_d_out;
  logic [15:0] req_addr_in, cur_addr;
  logic [7:0] muxed_address_out, row_seen, ref_row;
  dsct_op_t req_op_in, cur_op;
  logic ref_mem [65536];
  logic [31:0] rng;
  logic cas_in_ras, wr_in_cas, rmw_seen;
  int err_total, n_compared, n_ras, n_ref, n0;
  realtime t_rel, t_rf, t_rr, t_cf, t_cr, t_wf, t_ref;

  dsct_ctrl #(.PWRUP_CYC(PW), .REF_CYC(RC)) uut (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .req_valid_in(req_valid_in),
    .req_op_in(req_op_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .req_page_in(req_page_in), .dram_q_in(dram_q_in), .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
    .init_done_out(init_done_out), .ras_n_out(ras_n_out), .cas_n_out(cas_n_out),
    .we_n_out(we_n_out), .muxed_address_out(muxed_address_out), .dram_d_out(dram_d_out));
  dsct_dram_model mem_model (.ras_n_in(ras_n_out), .cas_n_in(cas_n_out), .we_n_in(we_n_out),
    .addr_in(muxed_address_out), .d_in(dram_d_out), .q_out(dram_q_in));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tchk(input string what, input logic ok);
    check(what, {7'h00, ok}, 8'h01);
  endtask : tchk

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  // entered just after an edge; returns just after an edge
  task automatic access(input dsct_op_t op, input logic [15:0] a, input logic wd, input logic pg);
    int n;
    logic exp;
    exp = ref_mem[a];
    cur_op = op;
    cur_addr = a;
    req_valid_in = 1'b1;
    req_op_in = op;
    req_addr_in = a;
    req_wdata_in = wd;
    req_page_in = pg;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (req_ready_out !== 1'b1 && n < 3000);
    #1 req_valid_in = 1'b0;
    tchk("ready_wait", n < 3000);
    if (op != DSCT_OP_WRITE) begin
      n = 0;
      do begin
        @(posedge core_clk_in);
        n++;
      end while (rsp_valid_out !== 1'b1 && n < 40);
      tchk("rsp_wait", n < 40);
      check("rdata", {7'h00, rsp_rdata_out}, {7'h00, exp});
    end else begin
      // from idle, column strobe falls two edges after the take (at the take on a page hit); hold the expectation until then
      repeat (2) @(posedge core_clk_in);
    end
    if (op != DSCT_OP_READ) ref_mem[a] = wd;
    #1;
  endtask : access

  always @(negedge ras_n_out) begin
    if (n_ras > 0) begin
      tchk("ras_pre", $realtime - t_rr >= 80);
      tchk("cyc_time", $realtime - t_rf >= (rmw_seen ? 255 : 230));
    end else tchk("pwrup", $realtime - t_rel >= (PW - 1) * 10);
    n_ras++;
    t_rf = $realtime;
    cas_in_ras = 1'b0;
    rmw_seen = 1'b0;
    #1 row_seen = muxed_address_out;
  end

  always @(posedge ras_n_out) begin
    if (n_ras > 0) begin
      tchk("ras_low", $realtime - t_rf >= 120 && $realtime - t_rf <= 10000);
      if (cas_in_ras) begin
        tchk("ras_hold", $realtime - t_cf >= 70);
        if (wr_in_cas) tchk("we_ras", $realtime - t_wf >= 50);
      end else begin
        if (n_ref > 9) tchk("ref_row", row_seen == ref_row + 8'h01);
        if (n_ref > 9) tchk("ref_gap", $realtime - t_ref <= (RC + 100) * 10);
        ref_row = row_seen;
        t_ref = t_rf;
        n_ref++;
      end
    end
    t_rr = $realtime;
  end

  always @(negedge cas_n_out) begin
    if (!cas_in_ras) tchk("rcd", $realtime - t_rf >= 15 && $realtime - t_rf <= 50);
    else begin
      tchk("cas_pre", $realtime - t_cr >= 50);
      tchk("page_cyc", $realtime - t_cf >= 130);
    end
    cas_in_ras = 1'b1;
    t_cf = $realtime;
    #1;
    wr_in_cas = !we_n_out;
    check("row", row_seen, cur_addr[15:8]);
    check("col", muxed_address_out, cur_addr[7:0]);
    tchk("early_we", we_n_out == (cur_op != DSCT_OP_WRITE));
  end

  always @(posedge cas_n_out) begin
    if (cas_in_ras) begin
      tchk("cas_low", $realtime - t_cf >= 70 && $realtime - t_cf <= 10000);
      tchk("cas_hold", $realtime - t_rf >= 120);
      if (wr_in_cas) tchk("we_cas", $realtime - t_wf >= 50);
    end
    t_cr = $realtime;
  end

  always @(negedge we_n_out) begin
    t_wf = $realtime;
    #1;
    if (!cas_n_out && t_wf > t_cf) begin
      tchk("rmw_dly", t_wf - t_cf >= 40 && t_wf - t_rf >= 110);
      rmw_seen = 1'b1;
      wr_in_cas = 1'b1;
    end
  end

  always @(posedge we_n_out) if (t_wf > 0) tchk("we_pulse", $realtime - t_wf >= 40);
  always @(posedge init_done_out) check("init_ras", n_ras[7:0], 8'h08);

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  initial begin
    #400000;
    err_total++;
    wrap_up();
  end

  initial begin
    srst_in = 1'b1;
    req_valid_in = 1'b0;
    req_op_in = DSCT_OP_READ;
    req_addr_in = 16'h0000;
    req_wdata_in = 1'b0;
    req_page_in = 1'b0;
    cas_in_ras = 1'b0;
    wr_in_cas = 1'b0;
    rmw_seen = 1'b0;
    rng = 32'h6637;
    for (int i = 0; i < 65536; i++) ref_mem[i] = 1'b0;
    repeat (6) @(posedge core_clk_in);
    #1 srst_in = 1'b0;
    t_rel = $realtime + 9;
    // presented during initialisation; must wait for it
    access(DSCT_OP_WRITE, 16'hffff, 1'b1, 1'b0);
    tchk("init_first", init_done_out);
    $display("test init done");
    access(DSCT_OP_WRITE, 16'h0000, 1'b1, 1'b0);
    access(DSCT_OP_READ, 16'hffff, 1'b0, 1'b0);
    access(DSCT_OP_RMW, 16'hffff, 1'b0, 1'b1);
    access(DSCT_OP_READ, 16'hffff, 1'b0, 1'b0);
    for (int j = 0; j < 8; j++)
      access(j < 4 ? DSCT_OP_WRITE : DSCT_OP_READ, 16'h12a0 + 16'(j % 4), j[0], j != 7);
    $display("test corners done");
    for (int i = 0; i < 40; i++) begin
      rng = xs(rng);
      access(dsct_op_t'(rng[31:30] % 2'h3), {6'h30, rng[9:0]}, rng[12], rng[13]);
    end
    $display("test random done");
    n0 = n_ref;
    repeat (3 * RC) @(posedge core_clk_in);
    tchk("idle_refresh", n_ref - n0 >= 2);
    $display("test refresh done");
    wrap_up();
  end
endmodule : dsct_ctrl_tb
